// >>> rtl/rpsc_cfg.svh
// Purpose: Offsets, field positions, reset values and counts for the slot status and
//          root control block.
// Assumes: Byte addresses in the port's configuration space; 16-bit registers.
// Notes: Macro definitions only.
`ifndef RPSC_CFG_SVH
`define RPSC_CFG_SVH

`define RPSC_SLOT_FLAGS_OFS 8'hba
`define RPSC_ROOT_CTRL_OFS 8'hbc

`define RPSC_SF_ABP 0
`define RPSC_SF_PDC 3
`define RPSC_SF_CC 4
`define RPSC_SF_PDS 6

`define RPSC_RC_SECE 0
`define RPSC_RC_SENFE 1
`define RPSC_RC_SEFE 2
`define RPSC_RC_PMEIE 3

`define RPSC_SLOT_FLAGS_RST 16'h0000
`define RPSC_ROOT_CTRL_RST 4'h0

// Cycles after reset before pin edges count; must outlast the four-edge synchroniser fill,
// or a card already present at reset would log a false presence change
`define RPSC_ARM_CYCLES 3'h5

`endif

// >>> rtl/rpsc_pkg.sv
// Purpose: Carrier and state types for the slot status and root control block.
// Assumes: Constants live in rpsc_cfg.svh.
// Notes: Types only.
package rpsc_pkg;

  // Configuration access request, one cycle each
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] be;
    logic [7:0] addr;
    logic [15:0] wdata;
  } rpsc_cfg_req_type;

  // Error reports, one-cycle pulses
  typedef struct packed {
    logic fatal;
    logic nonfatal;
    logic corr;
  } rpsc_err_type;

  // Slot event enables held by the slot control register
  typedef struct packed {
    logic hp_en;
    logic cc_en;
    logic pdc_en;
    logic abp_en;
  } rpsc_slot_en_type;

  typedef struct packed {
    logic abp;
    logic pdc;
    logic cc;
    logic pds_prev;
    logic btn_prev;
    logic [2:0] arm_cnt;
    logic [3:0] root_ctl;
    logic pme_status;
    logic pme_pending;
    logic ien_prev;
    logic hp_int;
    logic pme_int;
    logic serr;
    logic [15:0] rdata;
    logic rvalid;
  } rpsc_top_state_type;

endpackage

// >>> rtl/rpsc_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs asynchronous to mclk.
// Notes: Output moves only when stages two and three agree.
module rpsc_sync #(
  parameter int W = 2
) (
  input wire logic mclk, // Core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [W-1:0] pin, // Raw pin levels
  output logic [W-1:0] lvl // Filtered levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } rpsc_sync_state_type;

  rpsc_sync_state_type s_q, s_d;
  logic [W-1:0] agree;

  if (W < 1) begin : g_chk
    $error("rpsc_sync: W must be at least 1");
  end

  // First stage feeds only the second; a glitch that splits stages two and three is held off
  assign agree = s_q.s2 ~^ s_q.s3;
  always_comb begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.out = (agree & s_q.s3) | (~agree & s_q.out);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lvl = s_q.out;

  agree_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
    s_q.s2 == s_q.s3 |=> s_q.out == $past(s_q.s3))
    else $error("Synchroniser output missed an agreed level");

endmodule

// >>> rtl/rpsc_top.sv
// Purpose: Slot event flags and root error and PME control for one root port.
// Assumes: Configuration accesses arrive as one-cycle requests on mclk; event inputs
//          other than the two pins are one-cycle pulses on mclk.
// Notes: Read data returns one cycle after the request; unmapped offsets read zero.
`include "rpsc_cfg.svh"

module rpsc_top #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk, // Core clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input rpsc_pkg::rpsc_cfg_req_type cfg_req, // Configuration access
  output logic [15:0] cfg_rdata, // Read data
  output logic cfg_rvalid, // Read data valid pulse
  input wire logic presence_pin, // Card present level, asynchronous
  input wire logic attn_button_pin, // Attention button, high while pressed
  input wire logic cmd_done, // Hot-plug command finished pulse
  input rpsc_pkg::rpsc_slot_en_type slot_en, // Slot event enables
  input wire logic pme_msg, // PME message received pulse
  input wire logic pme_status_clr, // Software writes 1 to PME status
  input rpsc_pkg::rpsc_err_type err_local, // Errors the port logs itself
  input rpsc_pkg::rpsc_err_type err_msg, // Error messages from the link
  output logic hp_int, // Hot-plug interrupt level
  output logic pme_int, // PME interrupt pulse
  output logic serr, // System error pulse
  output logic pme_status, // PME status flag
  output logic pme_pending // Another PME waiting
);

  rpsc_pkg::rpsc_top_state_type s_q, s_d;
  logic [1:0] pin_lvl;
  logic pds, btn, armed, wr_slot, wr_root, ien_rise, pme_set_evt;
  logic [7:0] clr;
  logic [2:0] err_any;

  if (ADDR_W != 8) begin : g_chk
    $error("rpsc_top: ADDR_W must be 8");
  end

  // Offset match used by write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:1] == ofs[7:1]);
  endfunction

  rpsc_sync #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin({attn_button_pin, presence_pin}),
    .lvl(pin_lvl)
  );

  // Event and decode terms shared by the next-state logic and the checks
  assign pds = pin_lvl[0];
  assign btn = pin_lvl[1];
  assign armed = (s_q.arm_cnt == `RPSC_ARM_CYCLES);
  assign wr_slot = cfg_req.wr && cfg_req.be[0] && hit(cfg_req.addr, `RPSC_SLOT_FLAGS_OFS);
  assign wr_root = cfg_req.wr && cfg_req.be[0] && hit(cfg_req.addr, `RPSC_ROOT_CTRL_OFS);
  assign clr = wr_slot ? cfg_req.wdata[7:0] : 8'h00;
  assign ien_rise = s_q.root_ctl[`RPSC_RC_PMEIE] && !s_q.ien_prev;
  assign err_any = {err_local.fatal | err_msg.fatal, err_local.nonfatal | err_msg.nonfatal,
                    err_local.corr | err_msg.corr};
  // A new PME sets an idle flag; a clear with one waiting redelivers it at once
  assign pme_set_evt = (pme_msg && !s_q.pme_status) ||
                       (pme_status_clr && s_q.pme_status && (s_q.pme_pending || pme_msg));

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    // Ignore pin edges until the synchroniser holds real pin data
    if (!armed) begin
      s_d.arm_cnt = s_q.arm_cnt + 3'h1;
    end
    s_d.pds_prev = pds;
    s_d.btn_prev = btn;
    // Sticky flags: set term is OR-ed after the clear so an event is never lost
    s_d.cc = (s_q.cc && !clr[`RPSC_SF_CC]) || cmd_done;
    s_d.pdc = (s_q.pdc && !clr[`RPSC_SF_PDC]) || (armed && pds != s_q.pds_prev);
    s_d.abp = (s_q.abp && !clr[`RPSC_SF_ABP]) || (armed && btn && !s_q.btn_prev);
    // Only the four defined control bits are stored
    if (wr_root) begin
      s_d.root_ctl = cfg_req.wdata[3:0];
    end
    // PME status with one pending slot behind it
    if (pme_set_evt) begin
      s_d.pme_status = 1'b1;
      s_d.pme_pending = s_q.pme_status && s_q.pme_pending && pme_msg;
    end else if (pme_status_clr) begin
      s_d.pme_status = 1'b0;
    end else if (pme_msg && s_q.pme_status) begin
      s_d.pme_pending = 1'b1;
    end
    s_d.ien_prev = s_q.root_ctl[`RPSC_RC_PMEIE];
    s_d.pme_int = s_q.root_ctl[`RPSC_RC_PMEIE] &&
                  (pme_set_evt || (ien_rise && s_q.pme_status));
    // Command register enable is not consulted: these enables take precedence
    s_d.serr = |(s_q.root_ctl[2:0] & err_any);
    s_d.hp_int = slot_en.hp_en && ((s_d.cc && slot_en.cc_en) ||
                 (s_d.pdc && slot_en.pdc_en) || (s_d.abp && slot_en.abp_en));
    // Read mux; reserved bits and unmapped offsets return zero
    if (cfg_req.rd) begin
      s_d.rvalid = 1'b1;
      if (hit(cfg_req.addr, `RPSC_SLOT_FLAGS_OFS)) begin
        s_d.rdata = {9'h000, pds, 1'b0, s_q.cc, s_q.pdc, 2'h0, s_q.abp};
      end else if (hit(cfg_req.addr, `RPSC_ROOT_CTRL_OFS)) begin
        s_d.rdata = {12'h000, s_q.root_ctl};
      end else begin
        s_d.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.root_ctl <= `RPSC_ROOT_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // All outputs straight from the state register
  assign cfg_rdata = s_q.rdata;
  assign cfg_rvalid = s_q.rvalid;
  assign hp_int = s_q.hp_int;
  assign pme_int = s_q.pme_int;
  assign serr = s_q.serr;
  assign pme_status = s_q.pme_status;
  assign pme_pending = s_q.pme_pending;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  cc_set_a: assert property (cmd_done |=> s_q.cc)
    else $error("Command completed flag not set");
  pdc_edge_a: assert property (armed && pds != s_q.pds_prev |=> s_q.pdc)
    else $error("Presence change flag missed an edge");
  abp_hold_a: assert property (s_q.abp && !clr[`RPSC_SF_ABP] |=> s_q.abp)
    else $error("Button flag dropped without a clear");
  flag_clear_a: assert property (wr_slot && cfg_req.wdata[`RPSC_SF_CC] && !cmd_done
    |=> !s_q.cc)
    else $error("Write one did not clear command flag");
  pme_irq_off_a: assert property (!s_q.root_ctl[`RPSC_RC_PMEIE] |=> !pme_int)
    else $error("PME interrupt while disabled");
  pme_irq_on_a: assert property (s_q.root_ctl[`RPSC_RC_PMEIE] && pme_msg && !s_q.pme_status
    |=> pme_int && pme_status)
    else $error("PME interrupt missing");
  pme_late_a: assert property ($rose(s_q.root_ctl[`RPSC_RC_PMEIE]) && s_q.pme_status
    |=> pme_int)
    else $error("Late PME enable gave no interrupt");
  pme_wait_a: assert property (s_q.pme_status && pme_msg && !pme_status_clr
    |=> pme_pending ##1 pme_status)
    else $error("PME not held pending");
  serr_on_a: assert property (s_q.root_ctl[`RPSC_RC_SEFE] && err_msg.fatal |=> serr)
    else $error("Fatal error raised no system error");
  serr_gate_a: assert property (!(|(s_q.root_ctl[2:0] & err_any)) |=> !serr)
    else $error("System error without enabled cause");
  hp_gate_a: assert property (!slot_en.hp_en |=> !hp_int)
    else $error("Hot-plug interrupt with master enable off");
  rsvd_zero_a: assert property (cfg_rvalid && $past(hit(cfg_req.addr, `RPSC_SLOT_FLAGS_OFS))
    |-> cfg_rdata[15:7] == 9'h000 && cfg_rdata[2:1] == 2'h0)
    else $error("Reserved slot bits read nonzero");

  // Sticky flags: held without a clear, cleared by a one, and an event beats a clear
  cc_keep_a: assert property (s_q.cc && !clr[`RPSC_SF_CC]
    |=> s_q.cc)
    else $error("Command completed flag dropped without a clear");
  set_wins_a: assert property (wr_slot && cfg_req.wdata[`RPSC_SF_CC] && cmd_done
    |=> s_q.cc)
    else $error("Clear won over a command completion in the same cycle");
  pdc_keep_a: assert property (s_q.pdc && !clr[`RPSC_SF_PDC]
    |=> s_q.pdc)
    else $error("Presence change flag dropped without a clear");
  pdc_clear_a: assert property (wr_slot && cfg_req.wdata[`RPSC_SF_PDC]
    && !(armed && pds != s_q.pds_prev) |=> !s_q.pdc)
    else $error("Write one did not clear presence change flag");
  abp_set_a: assert property (armed && btn && !s_q.btn_prev
    |=> s_q.abp)
    else $error("Button press did not set its flag");
  abp_clear_a: assert property (wr_slot && cfg_req.wdata[`RPSC_SF_ABP]
    && !(armed && btn && !s_q.btn_prev) |=> !s_q.abp)
    else $error("Write one did not clear button flag");

  // Control register: only a low-byte write changes it, and reads return it unmasked
  ctl_write_a: assert property (wr_root
    |=> s_q.root_ctl == $past(cfg_req.wdata[3:0]))
    else $error("Control write did not land");
  ctl_keep_a: assert property (!wr_root
    |=> $stable(s_q.root_ctl))
    else $error("Control bits changed without a write");
  ctl_read_a: assert property (cfg_req.rd && hit(cfg_req.addr, `RPSC_ROOT_CTRL_OFS)
    |=> cfg_rdata == {12'h000, $past(s_q.root_ctl)})
    else $error("Control read returned wrong data");
  pds_read_a: assert property (cfg_req.rd && hit(cfg_req.addr, `RPSC_SLOT_FLAGS_OFS)
    |=> cfg_rdata[`RPSC_SF_PDS] == $past(pds))
    else $error("Presence bit read does not follow the pin");

  // System error from each enabled cause and either source
  serr_local_a: assert property (s_q.root_ctl[`RPSC_RC_SEFE] && err_local.fatal
    |=> serr)
    else $error("Local fatal error raised no system error");
  serr_nonfatal_a: assert property (s_q.root_ctl[`RPSC_RC_SENFE]
    && (err_local.nonfatal || err_msg.nonfatal) |=> serr)
    else $error("Non-fatal error raised no system error");
  serr_corr_a: assert property (s_q.root_ctl[`RPSC_RC_SECE]
    && (err_local.corr || err_msg.corr) |=> serr)
    else $error("Correctable error raised no system error");

  // Interrupt paths that must fire, not only stay quiet
  hp_cmd_a: assert property (slot_en.hp_en && slot_en.cc_en && cmd_done
    |=> hp_int)
    else $error("Enabled command completion gave no hot-plug interrupt");
  hp_pdc_a: assert property (slot_en.hp_en && slot_en.pdc_en && s_q.pdc
    && !clr[`RPSC_SF_PDC] |=> hp_int)
    else $error("Enabled presence change gave no hot-plug interrupt");
  pme_redeliver_a: assert property (s_q.pme_status && s_q.pme_pending && pme_status_clr
    |=> pme_status && pme_int == $past(s_q.root_ctl[`RPSC_RC_PMEIE]))
    else $error("Pending PME not delivered on clear");
  pme_clear_a: assert property (pme_status_clr && s_q.pme_status
    && !s_q.pme_pending && !pme_msg |=> !pme_status)
    else $error("PME status not cleared");

endmodule

// >>> verification/rpsc_slot_model.sv
// Purpose: Slot hardware and downstream hierarchy facing the block.
// Assumes: Driven just after falling edges of mclk.
// Notes: Pins are levels; the other events are one-cycle pulses.
module rpsc_slot_model (
  input wire logic mclk, // Core clock
  output logic presence_pin, // Card present level
  output logic attn_button_pin, // Button level
  output logic cmd_done, // Command done pulse
  output logic pme_msg, // PME message pulse
  output rpsc_pkg::rpsc_err_type err_local, // Port-logged errors
  output rpsc_pkg::rpsc_err_type err_msg // Link error messages
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet slot at time zero
  initial begin
    {presence_pin, attn_button_pin, cmd_done, pme_msg} = 4'h0;
    err_local = 3'h0;
    err_msg = 3'h0;
  end

  // Full-cycle pulse so exactly one rising edge samples it
  task automatic ev(input logic cd, input logic pm, input logic [2:0] el,
                    input logic [2:0] em);
    @(negedge mclk);
    {cmd_done, pme_msg, err_local, err_msg} = {cd, pm, el, em};
    @(negedge mclk);
    {cmd_done, pme_msg, err_local, err_msg} = 8'h00;
  endtask

  // Pin levels change only at falling edges, never at a rising one
  task automatic pins(input logic p, input logic b);
    @(negedge mclk);
    presence_pin = p;
    attn_button_pin = b;
  endtask
endmodule

// >>> verification/test_root_port_slot_status_ctrl.sv
// Purpose: Self-checking bench for the slot flags and root control block.
// Assumes: Inputs change at falling edges; outputs sampled there too.
// Notes: Pulse outputs are counted on rising edges and compared as deltas.
module test_root_port_slot_status_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  rpsc_pkg::rpsc_cfg_req_type cfg_req = '0;
  rpsc_pkg::rpsc_slot_en_type slot_en = 4'hf;
  logic pme_status_clr = 1'b0;
  logic [15:0] cfg_rdata;
  logic cfg_rvalid, hp_int, pme_int, serr, pme_status, pme_pending;
  logic presence_pin, attn_button_pin, cmd_done, pme_msg;
  rpsc_pkg::rpsc_err_type err_local, err_msg;
  int fails = 0;
  int tests_run = 0;
  int n_serr = 0;
  int n_pme = 0;
  int k, j, s0;

  always #5 mclk = ~mclk;

  // Pulse counters; a pulse that lasts two cycles shows as a wrong count
  always @(posedge mclk) begin
    if (serr === 1'b1) n_serr++;
    if (pme_int === 1'b1) n_pme++;
  end

  rpsc_slot_model u_slot (.mclk(mclk), .presence_pin(presence_pin),
    .attn_button_pin(attn_button_pin), .cmd_done(cmd_done), .pme_msg(pme_msg),
    .err_local(err_local), .err_msg(err_msg));

  rpsc_top #(.ADDR_W(8)) dut (.mclk(mclk), .rst_n(rst_n), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .presence_pin(presence_pin),
    .attn_button_pin(attn_button_pin), .cmd_done(cmd_done), .slot_en(slot_en),
    .pme_msg(pme_msg), .pme_status_clr(pme_status_clr), .err_local(err_local),
    .err_msg(err_msg), .hp_int(hp_int), .pme_int(pme_int), .serr(serr),
    .pme_status(pme_status), .pme_pending(pme_pending));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(negedge mclk);
    cfg_req = '{rd: 1'b0, wr: 1'b1, be: be, addr: a, wdata: d};
    @(negedge mclk);
    cfg_req.wr = 1'b0;
  endtask

  // Read waits a bounded few cycles for the valid pulse
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    int i;
    @(negedge mclk);
    cfg_req = '{rd: 1'b1, wr: 1'b0, be: 2'h3, addr: a, wdata: 16'h0000};
    @(negedge mclk);
    cfg_req.rd = 1'b0;
    for (i = 0; i < 3 && cfg_rvalid !== 1'b1; i++) @(negedge mclk);
    chk({15'h0000, cfg_rvalid}, 16'h0001);
    chk(cfg_rdata, exp);
  endtask

  // Enables settle two falling edges before the interrupt level is looked at
  task automatic en_chk(input logic [3:0] en, input logic exp);
    @(negedge mclk);
    slot_en = en;
    repeat (2) @(negedge mclk);
    chk({15'h0000, hp_int}, {15'h0000, exp});
  endtask

  task automatic clr_pme;
    @(negedge mclk);
    pme_status_clr = 1'b1;
    @(negedge mclk);
    pme_status_clr = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Whole run is well under a few thousand cycles
  initial begin
    #40000;
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    rdchk(8'hba, 16'h0000);
    rdchk(8'hbc, 16'h0000);
    cfg_wr(8'hbc, 16'hffff, 2'h1);
    rdchk(8'hbc, 16'h000f);
    cfg_wr(8'hbc, 16'h0000, 2'h2);
    rdchk(8'hbc, 16'h000f);
    cfg_wr(8'hb0, 16'hffff, 2'h3);
    rdchk(8'hb0, 16'h0000);
    $display("test registers done");
    cfg_wr(8'hbc, 16'h0000, 2'h1);
    en_chk(4'h7, 1'b0);
    u_slot.ev(1'b1, 1'b0, 3'h0, 3'h0);
    rdchk(8'hba, 16'h0010);
    en_chk(4'h7, 1'b0);
    en_chk(4'hb, 1'b0);
    en_chk(4'hf, 1'b1);
    cfg_wr(8'hba, 16'h0000, 2'h1);
    rdchk(8'hba, 16'h0010);
    // Clear and a fresh completion land on the same edge
    fork
      cfg_wr(8'hba, 16'h0010, 2'h1);
      u_slot.ev(1'b1, 1'b0, 3'h0, 3'h0);
    join
    rdchk(8'hba, 16'h0010);
    cfg_wr(8'hba, 16'h0010, 2'h1);
    rdchk(8'hba, 16'h0000);
    en_chk(4'hf, 1'b0);
    u_slot.pins(1'b1, 1'b0);
    repeat (10) @(negedge mclk);
    rdchk(8'hba, 16'h0048);
    en_chk(4'h9, 1'b0);
    en_chk(4'ha, 1'b1);
    cfg_wr(8'hba, 16'hffff, 2'h1);
    rdchk(8'hba, 16'h0040);
    u_slot.pins(1'b0, 1'b0);
    repeat (10) @(negedge mclk);
    rdchk(8'hba, 16'h0008);
    u_slot.pins(1'b0, 1'b1);
    repeat (10) @(negedge mclk);
    u_slot.pins(1'b0, 1'b0);
    rdchk(8'hba, 16'h0009);
    cfg_wr(8'hba, 16'h0009, 2'h1);
    rdchk(8'hba, 16'h0000);
    $display("test slot flags done");
    // One enable at a time, then none; every error kind from both sources
    for (k = 0; k < 4; k++) begin
      cfg_wr(8'hbc, 16'h0001 << k & 16'h0007, 2'h1);
      s0 = n_serr;
      for (j = 0; j < 3; j++) begin
        u_slot.ev(1'b0, 1'b0, 3'h1 << j, 3'h0);
        u_slot.ev(1'b0, 1'b0, 3'h0, 3'h1 << j);
      end
      repeat (3) @(negedge mclk);
      chk(16'(n_serr - s0), (k < 3) ? 16'h0002 : 16'h0000);
    end
    $display("test system error done");
    s0 = n_pme;
    u_slot.ev(1'b0, 1'b1, 3'h0, 3'h0);
    repeat (3) @(negedge mclk);
    chk({15'h0000, pme_status}, 16'h0001);
    chk(16'(n_pme - s0), 16'h0000);
    cfg_wr(8'hbc, 16'h0008, 2'h1);
    repeat (4) @(negedge mclk);
    chk(16'(n_pme - s0), 16'h0001);
    u_slot.ev(1'b0, 1'b1, 3'h0, 3'h0);
    repeat (3) @(negedge mclk);
    chk({15'h0000, pme_pending}, 16'h0001);
    chk(16'(n_pme - s0), 16'h0001);
    clr_pme();
    chk({14'h0000, pme_status, pme_pending}, 16'h0002);
    chk(16'(n_pme - s0), 16'h0002);
    clr_pme();
    chk({15'h0000, pme_status}, 16'h0000);
    u_slot.ev(1'b0, 1'b1, 3'h0, 3'h0);
    repeat (3) @(negedge mclk);
    chk(16'(n_pme - s0), 16'h0003);
    $display("test pme done");
    report_and_stop();
  end
endmodule
